// ==== src/map_lock_pkg.sv ====
// Purpose: Shared constants and types for the register map lock and checksum block.
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register.
// Notes: Printed register offsets are word indices; the byte address is four times the index.
package map_lock_pkg;
   localparam int NUM_REGS = 32;
   localparam logic [4:0] LOCK_INDEX = 5'h1F;
   localparam logic [4:0] FIRST_WRITABLE = 5'h00;
   localparam logic [4:0] LAST_WRITABLE = 5'h1E;
   localparam logic [4:0] IRQ_STATUS_INDEX = 5'h1C;
   localparam logic [4:0] IRQ_MASK_INDEX = 5'h1D;
   localparam logic [7:0] PASSWORD = 8'hA5;
   localparam int LOCK_LSB = 16;
   localparam int LOCK_MSB = 23;
   localparam int CRC_MSB = 15;
   localparam int REG_WIDTH = 24;
   localparam logic [23:0] REG_RESET = 24'h00_0000;
   localparam logic [15:0] CRC_RESET = 16'h0000;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam int CRC_PERIOD_CYCLES = 25;
   localparam logic [4:0] CRC_PERIOD_LAST = 5'(CRC_PERIOD_CYCLES - 1);
   localparam logic [31:0] UNDEFINED_READ = 32'hDEAD_BEEF;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam int IRQ_CRC_BIT = 0;

   typedef struct packed {
      logic [4:0] index;
      logic [23:0] data;
   } reg_write_t;
endpackage : map_lock_pkg

// ==== src/map_crc_engine.sv ====
// Purpose: Folds 24-bit words of the writable map into a CRC-16, up to two words per cycle.
// Assumes: The caller presents words in index order while running; pair says the second word counts.
// Notes: Polynomial and start value come from the package; MSB of each word goes first.
`timescale 1ns/1ps
module map_crc_engine
   import map_lock_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic step,
   input wire logic pair,
   input wire logic [23:0] word,
   input wire logic [23:0] word_next,
   // Result
   output logic [15:0] crc
);
   function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [23:0] w);
      logic [15:0] r;
      r = c;
      for (int i = REG_WIDTH - 1; i >= 0; i--)
      begin
         r = (r[15] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc_word

   always_ff @(posedge clk)
   begin
      if (rst || start)
         crc <= CRC_INIT;
      else if (step && pair)
         crc <= crc_word(crc_word(crc, word), word_next);
      else if (step)
         crc <= crc_word(crc, word);
   end
endmodule : map_crc_engine

// ==== src/map_lock_regs.sv ====
// Purpose: AXI4-Lite register map with password lock and a periodic CRC-16 over the writable map.
// Assumes: One clock REF_CLK standing in for the digital master clock, synchronous active-high RST.
// Notes: Offset 0x1F holds lock and checksum; indices 0x1C and 0x1D hold interrupt status and mask.
//    The checksum walk folds two words per cycle so that a full pass fits in one refresh period.
//    The status bit sets on each checksum change while locked, except the first result after locking; the mask only gates the pin.
`timescale 1ns/1ps
module map_lock_regs
   import map_lock_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // AXI4-Lite write address and data
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Interrupt
   output logic IRQ
);
   typedef enum logic [1:0] {
      CRC_IDLE = 2'b00,
      CRC_RUN = 2'b01,
      CRC_WAIT = 2'b11
   } crc_state_t;

   typedef struct packed {
      // Register contents and lock.
      logic [NUM_REGS-1:0][23:0] regs;
      logic [7:0] lock;
      logic [15:0] checksum;
      logic [23:0] irq_status;
      logic [23:0] irq_mask;
      // Checksum walk.
      crc_state_t crc_state;
      logic [4:0] period;
      logic [4:0] walk;
      // Bus channels.
      logic have_aw;
      logic have_w;
      logic aw_ready;
      logic w_ready;
      logic ar_ready;
      logic [4:0] aw_index;
      logic aw_bad;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic irq;
   } state_t;

   state_t q;
   state_t next_q;
   logic [15:0] crc;
   logic crc_start;
   logic crc_step;
   logic [23:0] crc_word;
   logic [23:0] crc_word_next;
   logic crc_pair;
   localparam logic [4:0] WALK_STRIDE = 5'h02;

   function automatic logic addr_bad(input logic [31:0] a);
      return (a[1:0] != 2'b00) || (a[31:7] != '0);
   endfunction : addr_bad

   // Word index from a byte address; alignment is judged separately.
   function automatic logic [4:0] addr_index(input logic [31:0] a);
      return a[6:2];
   endfunction : addr_index

   function automatic logic [23:0] map_word(input state_t s, input logic [4:0] idx);
      logic [23:0] r;
      case (idx)
         IRQ_STATUS_INDEX: r = s.irq_status;
         IRQ_MASK_INDEX: r = s.irq_mask;
         default: r = s.regs[idx];
      endcase
      return r;
   endfunction : map_word

   function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [23:0] r;
      r = old;
      for (int b = 0; b < 3; b++)
      begin
         if (s[b])
            r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r;
   endfunction : merge

   // Writable words are the plain registers; status and mask join the message as well.
   // Two words go in per cycle, so 31 words take 16 cycles and leave slack in the 25-cycle period.
   assign crc_word = map_word(q, q.walk);
   assign crc_word_next = map_word(q, q.walk + 5'd1);
   assign crc_pair = (q.walk != LAST_WRITABLE);

   // A fresh walk starts from the seed: on locking, and in the cycle that hands over the last result.
   assign crc_start = (q.crc_state == CRC_IDLE) ||
      ((q.crc_state == CRC_WAIT) && (q.period == CRC_PERIOD_LAST));
   assign crc_step = (q.crc_state == CRC_RUN);

   map_crc_engine crc_engine (
      .clk(REF_CLK),
      .rst(RST),
      .start(crc_start),
      .step(crc_step),
      .pair(crc_pair),
      .word(crc_word),
      .word_next(crc_word_next),
      .crc(crc)
   );

   always_comb
   begin
      logic unlocked;
      logic [23:0] lock_word;
      logic write_fire;
      logic [23:0] crc_event;
      unlocked = 1'b0;
      lock_word = REG_RESET;
      write_fire = 1'b0;
      crc_event = REG_RESET;
      next_q = q;
      unlocked = (q.lock == PASSWORD);

      // Address and data may arrive in either order; each is held until both are present.
      if (S_AXI_AWVALID && !q.have_aw)
      begin
         next_q.have_aw = 1'b1;
         next_q.aw_index = addr_index(S_AXI_AWADDR);
         next_q.aw_bad = addr_bad(S_AXI_AWADDR);
      end
      if (S_AXI_WVALID && !q.have_w)
      begin
         next_q.have_w = 1'b1;
         next_q.wdata = S_AXI_WDATA;
         next_q.wstrb = S_AXI_WSTRB;
      end
      write_fire = q.have_aw && q.have_w && !q.bvalid;

      // The checksum walks the writable words, then idles to fill out the refresh period.
      if (q.period == CRC_PERIOD_LAST)
         next_q.period = '0;
      else
         next_q.period = q.period + 5'd1;
      case (q.crc_state)
         CRC_IDLE:
         begin
            if (!unlocked)
            begin
               next_q.crc_state = CRC_RUN;
               next_q.walk = FIRST_WRITABLE;
               next_q.period = '0;
            end
         end
         CRC_RUN:
         begin
            if (q.walk == LAST_WRITABLE)
               next_q.crc_state = CRC_WAIT;
            else
               next_q.walk = q.walk + WALK_STRIDE;
         end
         CRC_WAIT:
         begin
            if (q.period == CRC_PERIOD_LAST)
            begin
               next_q.checksum = crc;
               next_q.crc_state = CRC_RUN;
               next_q.walk = FIRST_WRITABLE;
               // A changed map while locked is the interrupt event.
               // Writes cannot reach the map while locked, so this flags a corrupted register.
               if (crc != q.checksum && q.checksum != CRC_RESET)
                  crc_event[IRQ_CRC_BIT] = 1'b1;
            end
         end
         default: next_q.crc_state = CRC_IDLE;
      endcase

      // Locked writes other than the lock word still answer OKAY but change nothing.
      if (write_fire)
      begin
         next_q.have_aw = 1'b0;
         next_q.have_w = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = q.aw_bad ? RESP_SLVERR : RESP_OKAY;
         if (!q.aw_bad)
         begin
            if (q.aw_index == LOCK_INDEX)
            begin
               lock_word = merge({q.lock, q.checksum}, q.wdata, q.wstrb);
               next_q.lock = lock_word[LOCK_MSB:LOCK_LSB];
            end
            else if (unlocked)
            begin
               case (q.aw_index)
                  IRQ_STATUS_INDEX: next_q.irq_status = q.irq_status & ~merge(REG_RESET, q.wdata, q.wstrb);
                  IRQ_MASK_INDEX: next_q.irq_mask = merge(q.irq_mask, q.wdata, q.wstrb);
                  default: next_q.regs[q.aw_index] = merge(q.regs[q.aw_index], q.wdata, q.wstrb);
               endcase
            end
         end
      end
      if (q.bvalid && S_AXI_BREADY)
         next_q.bvalid = 1'b0;

      // Set wins over a clear in the same cycle.
      next_q.irq_status = next_q.irq_status | crc_event;

      // Unlocking discards any walk in progress; the next lock starts a fresh one.
      if (unlocked)
      begin
         next_q.checksum = CRC_RESET;
         next_q.irq_status[IRQ_CRC_BIT] = 1'b0;
         next_q.crc_state = CRC_IDLE;
      end

      // A read answers one cycle after its address is taken and holds until accepted.
      if (S_AXI_ARVALID && !q.rvalid)
      begin
         next_q.rvalid = 1'b1;
         next_q.rresp = RESP_OKAY;
         if (addr_bad(S_AXI_ARADDR))
         begin
            next_q.rdata = '0;
            next_q.rresp = RESP_SLVERR;
         end
         else if (addr_index(S_AXI_ARADDR) == LOCK_INDEX)
            next_q.rdata = {8'h00, q.lock, q.checksum};
         else if (!unlocked)
            next_q.rdata = UNDEFINED_READ;
         else
            next_q.rdata = {8'h00, map_word(q, addr_index(S_AXI_ARADDR))};
      end
      else if (q.rvalid && S_AXI_RREADY)
         next_q.rvalid = 1'b0;

      next_q.irq = |(next_q.irq_status & next_q.irq_mask);

      // Ready flags are registered so that every bus output comes straight from a flip-flop.
      next_q.aw_ready = !next_q.have_aw;
      next_q.w_ready = !next_q.have_w;
      next_q.ar_ready = !next_q.rvalid;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         q <= '0;
         q.lock <= PASSWORD;
         q.crc_state <= CRC_IDLE;
         q.aw_ready <= 1'b1;
         q.w_ready <= 1'b1;
         q.ar_ready <= 1'b1;
      end
      else
         q <= next_q;
   end

   assign S_AXI_AWREADY = q.aw_ready;
   assign S_AXI_WREADY = q.w_ready;
   assign S_AXI_BVALID = q.bvalid;
   assign S_AXI_BRESP = q.bresp;
   assign S_AXI_ARREADY = q.ar_ready;
   assign S_AXI_RVALID = q.rvalid;
   assign S_AXI_RDATA = q.rdata;
   assign S_AXI_RRESP = q.rresp;
   assign IRQ = q.irq;
endmodule : map_lock_regs

// ==== tb/map_lock_regs_monitor.sv ====
// Purpose: Port-level checks of lock, checksum and bus answers.
// Assumes: The lock byte changes only by full-word writes to byte 0x7C.
// Notes: The lock value is tracked from writes seen at the ports.
`timescale 1ns/1ps
module map_lock_regs_monitor
   import map_lock_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Write channels
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   // Read channels
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   // Interrupt
   input wire logic IRQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic [7:0] lock_val;
   logic locked;
   logic wf;
   logic rf;
   logic bad_w;
   assign wf = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   assign rf = S_AXI_ARVALID && S_AXI_ARREADY;
   assign locked = lock_val != PASSWORD;
   assign bad_w = S_AXI_AWADDR[1:0] != 2'b00 || S_AXI_AWADDR > 32'h0000_007F;
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
         lock_val <= PASSWORD;
      else if (wf && S_AXI_AWADDR == 32'h0000_007C)
         lock_val <= S_AXI_WDATA[23:16];
   end
   AST_LOCK_READ: assert property (rf && S_AXI_ARADDR == 32'h0000_007C |=> S_AXI_RDATA[31:16] == {8'h00, lock_val})
      else $error("lock field read mismatch");
   AST_UNDEF_READ: assert property (locked && rf && S_AXI_ARADDR < 32'h0000_007C && S_AXI_ARADDR[1:0] == 2'b00 |=> S_AXI_RDATA == UNDEFINED_READ)
      else $error("locked read not undefined");
   AST_CRC_CLEAR: assert property (!locked && rf && S_AXI_ARADDR == 32'h0000_007C |=> S_AXI_RDATA[15:0] == CRC_RESET)
      else $error("checksum not cleared while open");
   AST_IRQ_OFF: assert property ((!locked) [*4] |-> !IRQ)
      else $error("interrupt while open");
   AST_READ_ERR: assert property (rf && (S_AXI_ARADDR[1:0] != 2'b00 || S_AXI_ARADDR > 32'h0000_007F) |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
      else $error("bad read address not refused");
   AST_WRITE_ERR: assert property (wf && bad_w |-> ##[1:2] S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR)
      else $error("bad write address not refused");
   AST_WRITE_OK: assert property (wf && !bad_w |-> ##[1:2] S_AXI_BVALID && S_AXI_BRESP == RESP_OKAY)
      else $error("write answer missing");
   AST_READ_ANSWER: assert property (rf |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer late");
   cover property (locked && rf);
   cover property (wf && S_AXI_AWADDR == 32'h0000_007C);
   cover property (rf && S_AXI_ARADDR > 32'h0000_007F);
endmodule : map_lock_regs_monitor

bind map_lock_regs map_lock_regs_monitor u_map_lock_regs_monitor (
   .REF_CLK(REF_CLK),
   .RST(RST),
   .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARADDR(S_AXI_ARADDR),
   .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RRESP(S_AXI_RRESP),
   .S_AXI_RVALID(S_AXI_RVALID),
   .IRQ(IRQ)
);

// ==== tb/map_lock_regs_tb.sv ====
// Purpose: Directed test of the lock, checksum and error answers.
// Assumes: One outstanding access; all write strobes set.
// Notes: The checksum model mirrors the chosen polynomial and order.
`timescale 1ns/1ps
module map_lock_regs_tb
   import map_lock_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [23:0] mem [31];
   int fail_count = 0;
   int check_count = 0;
   map_lock_regs u_map_lock_regs (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .IRQ(irq));
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   task automatic summarize();
      if (fail_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", s, e, g);
         fail_count++;
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
      if (n == 20)
      begin
         fail_count++;
         summarize();
      end
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", 32'(er), 32'(rresp));
      if (n == 20)
      begin
         fail_count++;
         summarize();
      end
   endtask : rd
   function automatic logic [15:0] crc_of();
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 31; i++)
         for (int b = 23; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction : crc_of
   task automatic t_open();
      rd(32'h7C, 32'h00A5_0000, RESP_OKAY);
      wr(32'h04, 32'hFF12_3456, RESP_OKAY);
      rd(32'h04, 32'h0012_3456, RESP_OKAY);
      wr(32'h78, 32'h00AB_CDEF, RESP_OKAY);
      rd(32'h78, 32'h00AB_CDEF, RESP_OKAY);
      wr(32'h74, 32'h0000_0001, RESP_OKAY);
      wr(32'h7C, 32'h00A5_FFFF, RESP_OKAY);
      rd(32'h7C, 32'h00A5_0000, RESP_OKAY);
   endtask : t_open
   task automatic t_locked();
      wr(32'h7C, 32'h003C_0000, RESP_OKAY);
      wr(32'h04, 32'h0000_0BAD, RESP_OKAY);
      rd(32'h04, UNDEFINED_READ, RESP_OKAY);
      rd(32'h74, UNDEFINED_READ, RESP_OKAY);
      // The first checksum must land within one refresh period of locking; this read's address is taken 31 cycles after the lock takes effect.
      repeat (18) @(posedge clk);
      rd(32'h7C, {16'h003C, crc_of()}, RESP_OKAY);
      wr(32'h7C, 32'h003C_1234, RESP_OKAY);
      rd(32'h7C, {16'h003C, crc_of()}, RESP_OKAY);
      chk("irq", 32'h0, 32'(irq));
   endtask : t_locked
   task automatic t_reopen();
      wr(32'h7C, 32'h00A5_0000, RESP_OKAY);
      rd(32'h7C, 32'h00A5_0000, RESP_OKAY);
      rd(32'h04, 32'h0012_3456, RESP_OKAY);
      chk("irq", 32'h0, 32'(irq));
   endtask : t_reopen
   task automatic t_refused();
      rd(32'h80, 32'h0, RESP_SLVERR);
      rd(32'h06, 32'h0, RESP_SLVERR);
      wr(32'h81, 32'h1, RESP_SLVERR);
      wr(32'h100, 32'h1, RESP_SLVERR);
   endtask : t_refused
   initial
   begin
      foreach (mem[i])
         mem[i] = 24'h00_0000;
      mem[1] = 24'h12_3456;
      mem[29] = 24'h00_0001;
      mem[30] = 24'hAB_CDEF;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_open();
      t_locked();
      t_reopen();
      t_refused();
      summarize();
   end
endmodule : map_lock_regs_tb
